// ---- rtl/tps_pkg.sv ----
// tps_pkg: register map, field positions, reset values and colours
package tps_pkg;

  // register byte addresses on the control bus
  localparam logic [7:0]  ADDR_CTRL    = 8'h64; // pattern generator control
  localparam logic [7:0]  ADDR_CFG     = 8'h68; // invert, auto-advance, quad
  localparam logic [7:0]  ADDR_FTIME   = 8'h6C; // frames per auto step
  localparam logic [7:0]  ADDR_RED     = 8'h70; // custom red level
  localparam logic [7:0]  ADDR_GREEN   = 8'h74; // custom green level
  localparam logic [7:0]  ADDR_BLUE    = 8'h78; // custom blue level
  localparam logic [7:0]  ADDR_STAT    = 8'h7C; // read-only status

  // control register fields and reset value
  localparam int          CTRL_EN_BIT  = 0;     // generator_enable
  localparam int          CTRL_REV_BIT = 1;     // band_order_reverse
  localparam int          CTRL_BAR_BIT = 2;     // bar_pattern_enable
  localparam int          CTRL_CMP_BIT = 3;     // compliance_pattern_select
  localparam int          CTRL_SEL_LSB = 4;     // pattern_choice_field lsb
  localparam logic [7:0]  CTRL_RESET   = 8'h10;

  // configuration register fields
  localparam int          CFG_AUTO_BIT = 0;     // auto_advance_enable
  localparam int          CFG_INV_BIT  = 1;     // color_invert
  localparam int          CFG_QUAD_BIT = 2;     // quad band pattern enable
  localparam logic [7:0]  CFG_MASK     = 8'h07; // implemented cfg bits
  localparam logic [7:0]  FTIME_RESET  = 8'h01;

  // status register fields
  localparam int          STAT_CODE_LSB = 0;    // pattern now shown
  localparam int          STAT_EN_BIT   = 4;    // generator running
  localparam int          STAT_FRM_LSB  = 8;    // frames into the step

  // pattern codes
  localparam logic [3:0]  CODE_FIRST   = 4'h1;
  localparam logic [3:0]  CODE_WHITE   = 4'h1;
  localparam logic [3:0]  CODE_LAST    = 4'hE;

  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // colours as {red, green, blue}
  localparam logic [23:0] COL_WHITE    = 24'hFFFFFF;
  localparam logic [23:0] COL_BLACK    = 24'h000000;
  localparam logic [23:0] COL_RED      = 24'hFF0000;
  localparam logic [23:0] COL_GREEN    = 24'h00FF00;
  localparam logic [23:0] COL_BLUE     = 24'h0000FF;
  localparam logic [23:0] COL_CYAN     = 24'h00FFFF;
  localparam logic [23:0] COL_MAGENTA  = 24'hFF00FF;
  localparam logic [23:0] COL_YELLOW   = 24'hFFFF00;
  localparam logic [23:0] CMP_EVEN     = 24'hAAAAAA; // compliance checker
  localparam logic [23:0] CMP_ODD      = 24'h555555;

  // which source drives the pixels
  typedef enum logic [2:0] {
    SRC_OFF,
    SRC_COMPLIANCE,
    SRC_BARS,
    SRC_QUAD,
    SRC_CHOICE
  } tps_src_e;

endpackage : tps_pkg

// ---- rtl/tps_pixel.sv ----
// tps_pixel: turns scan position and pattern source into a registered pixel
`timescale 1ns/10ps
module tps_pixel #(
  parameter int H_ACTIVE = 1920,
  parameter int V_ACTIVE = 1080,
  parameter int H_W      = 12,
  parameter int V_W      = 11
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire tps_pkg::tps_src_e src,
  input  wire logic [3:0]       code,
  input  wire logic             invert,
  input  wire logic             band_rev,
  input  wire logic [23:0]      custom_rgb,
  input  wire logic [H_W-1:0]   x,
  input  wire logic [V_W-1:0]   y,
  output logic                  pix_valid,
  output logic [23:0]           pix_rgb
);

  typedef struct packed {
    logic        valid; // pixel qualifies
    logic [23:0] rgb;   // pixel colour
  } tps_pix_s;

  tps_pix_s s_q, s_d;

  logic [H_W+7:0] hprod;  // x scaled to 256 levels
  logic [V_W+7:0] vprod;  // y scaled to 256 levels
  logic [H_W+2:0] bprod;  // x scaled to 8 bars
  logic [H_W+1:0] qprod;  // x scaled to 4 bands
  logic [7:0]     hl;     // horizontal ramp level
  logic [7:0]     vl;     // vertical ramp level
  logic [23:0]    col;    // colour before inversion

  // colour of the next pixel, inverted as a whole at the end
  always_comb begin
    // even spread: level = position * 256 / active size
    hprod = {x, 8'h00} / (H_W+8)'(H_ACTIVE);
    vprod = {y, 8'h00} / (V_W+8)'(V_ACTIVE);
    bprod = {x, 3'h0} / (H_W+3)'(H_ACTIVE);
    qprod = {x, 2'h0} / (H_W+2)'(H_ACTIVE);
    hl    = hprod[7:0];
    vl    = vprod[7:0];
    col   = tps_pkg::COL_BLACK;
    case (src)
      tps_pkg::SRC_COMPLIANCE: begin
        // fine checker stresses every data bit toggling
        col = (x[0] ^ y[0]) ? tps_pkg::CMP_ODD : tps_pkg::CMP_EVEN;
      end
      tps_pkg::SRC_BARS: begin
        case (bprod[2:0])
          3'h0:    col = tps_pkg::COL_WHITE;
          3'h1:    col = tps_pkg::COL_YELLOW;
          3'h2:    col = tps_pkg::COL_CYAN;
          3'h3:    col = tps_pkg::COL_GREEN;
          3'h4:    col = tps_pkg::COL_MAGENTA;
          3'h5:    col = tps_pkg::COL_RED;
          3'h6:    col = tps_pkg::COL_BLUE;
          default: col = tps_pkg::COL_BLACK;
        endcase
      end
      tps_pkg::SRC_QUAD: begin
        // bands counted from the left edge
        case (qprod[1:0])
          2'h0:    col = band_rev ? tps_pkg::COL_BLUE : tps_pkg::COL_YELLOW;
          2'h1:    col = tps_pkg::COL_CYAN;
          2'h2:    col = band_rev ? tps_pkg::COL_YELLOW : tps_pkg::COL_BLUE;
          default: col = tps_pkg::COL_RED;
        endcase
      end
      tps_pkg::SRC_CHOICE: begin
        case (code)
          4'h1:    col = tps_pkg::COL_WHITE;
          4'h2:    col = tps_pkg::COL_BLACK;
          4'h3:    col = tps_pkg::COL_RED;
          4'h4:    col = tps_pkg::COL_GREEN;
          4'h5:    col = tps_pkg::COL_BLUE;
          4'h6:    col = {hl, hl, hl};
          4'h7:    col = {hl, 8'h00, 8'h00};
          4'h8:    col = {8'h00, hl, 8'h00};
          4'h9:    col = {8'h00, 8'h00, hl};
          4'hA:    col = {vl, vl, vl};
          4'hB:    col = {vl, 8'h00, 8'h00};
          4'hC:    col = {8'h00, vl, 8'h00};
          4'hD:    col = {8'h00, 8'h00, vl};
          4'hE:    col = custom_rgb;
          default: col = tps_pkg::COL_BLACK; // reserved codes show black
        endcase
      end
      default: col = tps_pkg::COL_BLACK;
    endcase
    s_d.valid = (src != tps_pkg::SRC_OFF);
    // inversion flips every bit, which maps white to black, red to cyan
    s_d.rgb   = (s_d.valid && invert) ? ~col :
                (s_d.valid ? col : tps_pkg::COL_BLACK);
  end

  // output register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pix_valid = s_q.valid;
  assign pix_rgb   = s_q.rgb;

endmodule : tps_pixel

// ---- rtl/tps_pattern_ctrl.sv ----
// tps_pattern_ctrl: test pattern control registers, scan and auto advance
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module tps_pattern_ctrl #(
  parameter int H_ACTIVE = 1920, // active pixels per line
  parameter int V_ACTIVE = 1080, // active lines per frame
  parameter int H_W      = 12,   // column counter width
  parameter int V_W      = 11    // line counter width
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // pixel stream
  output logic             pixel_valid,
  output logic [7:0]       pixel_red,
  output logic [7:0]       pixel_green,
  output logic [7:0]       pixel_blue
);

  localparam logic [H_W-1:0] H_LAST = H_W'(H_ACTIVE - 1); // last column
  localparam logic [V_W-1:0] V_LAST = V_W'(V_ACTIVE - 1); // last line

  // whole state of the block
  typedef struct packed {
    logic           aw_have; // write address held
    logic [7:0]     aw_addr; // held write address
    logic           w_have;  // write data held
    logic [31:0]    w_data;  // held write data
    logic [3:0]     w_strb;  // held byte strobes
    logic           bvalid;  // write response pending
    logic [1:0]     bresp;   // write response code
    logic           rvalid;  // read data pending
    logic [31:0]    rdata;   // read data
    logic [1:0]     rresp;   // read response code
    logic [7:0]     ctrl;    // pattern_generator_control
    logic [7:0]     cfg;     // invert, auto-advance, quad
    logic [7:0]     ftime;   // frames per auto step
    logic [7:0]     red;     // custom_red_level
    logic [7:0]     green;   // custom_green_level
    logic [7:0]     blue;    // custom_blue_level
    logic [H_W-1:0] x;       // scan column
    logic [V_W-1:0] y;       // scan line
    logic [7:0]     frames;  // frames shown in this step
    logic [3:0]     cur;     // pattern code now in use
  } tps_state_s;

  tps_state_s        s_q, s_d;
  tps_pkg::tps_src_e src;       // selected pixel source
  logic              gen_en;    // generator_enable
  logic              auto_on;   // auto_advance_enable
  logic              frame_end; // last pixel of a frame this cycle
  logic [7:0]        ftime_eff; // step length, zero taken as one
  logic              step_due;  // this frame completes a step
  logic [23:0]       pix_rgb;   // pixel from the colour stage
  logic [31:0]       stat_word; // status register image

  // handshake readies: one transfer of each kind in flight
  assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  // decoded control bits
  assign gen_en    = s_q.ctrl[tps_pkg::CTRL_EN_BIT];
  assign auto_on   = s_q.cfg[tps_pkg::CFG_AUTO_BIT];
  assign frame_end = gen_en && (s_q.x == H_LAST) && (s_q.y == V_LAST);
  assign ftime_eff = (s_q.ftime == 8'h00) ? 8'h01 : s_q.ftime;
  assign step_due  = ({1'b0, s_q.frames} + 9'h001) >= {1'b0, ftime_eff};

  // status: current code, running flag, frames into the step
  assign stat_word = {16'h0000, s_q.frames, 3'h0, gen_en, s_q.cur};

  // source priority: compliance over bars over quad over choice field
  always_comb begin
    if (!gen_en) begin
      src = tps_pkg::SRC_OFF;
    end else if (s_q.ctrl[tps_pkg::CTRL_CMP_BIT]) begin
      src = tps_pkg::SRC_COMPLIANCE;
    end else if (s_q.ctrl[tps_pkg::CTRL_BAR_BIT]) begin
      src = tps_pkg::SRC_BARS;
    end else if (s_q.cfg[tps_pkg::CFG_QUAD_BIT]) begin
      src = tps_pkg::SRC_QUAD;
    end else begin
      src = tps_pkg::SRC_CHOICE;
    end
  end

  // next state: bus slave, register file, scan and auto advance
  always_comb begin
    s_d = s_q;
    // capture write address and data independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    // both halves held: perform the write, answer next cycle
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = tps_pkg::RESP_OKAY;
      // registers are one byte wide, so only lane 0 matters
      if (s_q.aw_addr == tps_pkg::ADDR_CTRL) begin
        if (s_q.w_strb[0]) begin
          s_d.ctrl = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == tps_pkg::ADDR_CFG) begin
        if (s_q.w_strb[0]) begin
          s_d.cfg = s_q.w_data[7:0] & tps_pkg::CFG_MASK;
        end
      end else if (s_q.aw_addr == tps_pkg::ADDR_FTIME) begin
        if (s_q.w_strb[0]) begin
          s_d.ftime = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == tps_pkg::ADDR_RED) begin
        if (s_q.w_strb[0]) begin
          s_d.red = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == tps_pkg::ADDR_GREEN) begin
        if (s_q.w_strb[0]) begin
          s_d.green = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == tps_pkg::ADDR_BLUE) begin
        if (s_q.w_strb[0]) begin
          s_d.blue = s_q.w_data[7:0];
        end
      end else if (s_q.aw_addr == tps_pkg::ADDR_STAT) begin
        // status is read-only; the write is accepted and dropped
        s_d.bresp = tps_pkg::RESP_OKAY;
      end else begin
        s_d.bresp = tps_pkg::RESP_SLVERR; // unmapped address
      end
    end
    // response retires when the master takes it
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read: data registered in the cycle the address is taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = tps_pkg::RESP_OKAY;
      if (s_axi_araddr == tps_pkg::ADDR_CTRL) begin
        s_d.rdata = {24'h000000, s_q.ctrl};
      end else if (s_axi_araddr == tps_pkg::ADDR_CFG) begin
        s_d.rdata = {24'h000000, s_q.cfg};
      end else if (s_axi_araddr == tps_pkg::ADDR_FTIME) begin
        s_d.rdata = {24'h000000, s_q.ftime};
      end else if (s_axi_araddr == tps_pkg::ADDR_RED) begin
        s_d.rdata = {24'h000000, s_q.red};
      end else if (s_axi_araddr == tps_pkg::ADDR_GREEN) begin
        s_d.rdata = {24'h000000, s_q.green};
      end else if (s_axi_araddr == tps_pkg::ADDR_BLUE) begin
        s_d.rdata = {24'h000000, s_q.blue};
      end else if (s_axi_araddr == tps_pkg::ADDR_STAT) begin
        s_d.rdata = stat_word;
      end else begin
        s_d.rdata = 32'h00000000;
        s_d.rresp = tps_pkg::RESP_SLVERR; // unmapped address
      end
    end
    // raster scan over the active region only; parked while disabled
    if (!gen_en) begin
      s_d.x      = '0;
      s_d.y      = '0;
      s_d.frames = 8'h00;
    end else if (s_q.x == H_LAST) begin
      s_d.x = '0;
      s_d.y = (s_q.y == V_LAST) ? '0 : s_q.y + V_W'(1);
    end else begin
      s_d.x = s_q.x + H_W'(1);
    end
    // pattern code: follows the field in fixed mode, steps in auto mode
    if (!auto_on) begin
      s_d.cur    = s_q.ctrl[tps_pkg::CTRL_SEL_LSB +: 4];
      s_d.frames = 8'h00;
    end else if (frame_end) begin
      // the field is not looked at here, only the running code
      if (step_due) begin
        s_d.frames = 8'h00;
        // all fourteen defined codes count as enabled steps
        s_d.cur    = (s_q.cur >= tps_pkg::CODE_LAST) ?
                     tps_pkg::CODE_FIRST : s_q.cur + 4'h1;
      end else begin
        s_d.frames = s_q.frames + 8'h01;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.ctrl  <= tps_pkg::CTRL_RESET;
      s_q.ftime <= tps_pkg::FTIME_RESET;
      s_q.cur   <= tps_pkg::CODE_WHITE;
    end else begin
      s_q <= s_d;
    end
  end

  // colour stage, one cycle behind the scan
  tps_pixel #(
    .H_ACTIVE (H_ACTIVE),
    .V_ACTIVE (V_ACTIVE),
    .H_W      (H_W),
    .V_W      (V_W)
  ) u_pixel (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .src        (src),
    .code       (s_q.cur),
    .invert     (s_q.cfg[tps_pkg::CFG_INV_BIT]),
    .band_rev   (s_q.ctrl[tps_pkg::CTRL_REV_BIT]),
    .custom_rgb ({s_q.red, s_q.green, s_q.blue}),
    .x          (s_q.x),
    .y          (s_q.y),
    .pix_valid  (pixel_valid),
    .pix_rgb    (pix_rgb)
  );

  assign pixel_red   = pix_rgb[23:16];
  assign pixel_green = pix_rgb[15:8];
  assign pixel_blue  = pix_rgb[7:0];

  // helper terms for the checks below
  logic chk_inv;   // invert setting
  logic chk_x0;    // scan at first column
  logic chk_white; // solid white chosen
  logic chk_ramp;  // red ramp chosen
  assign chk_inv   = s_q.cfg[tps_pkg::CFG_INV_BIT];
  assign chk_x0    = (s_q.x == '0);
  assign chk_white = (src == tps_pkg::SRC_CHOICE) && (s_q.cur == 4'h1);
  assign chk_ramp  = (src == tps_pkg::SRC_CHOICE) && (s_q.cur == 4'h7);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_value_a: assert property (
    $past(!aresetn) |-> (s_q.ctrl == tps_pkg::CTRL_RESET) && !pixel_valid
  ) else $error("control register not at reset value");

  disabled_blank_a: assert property (
    !gen_en |=> !pixel_valid && (pix_rgb == tps_pkg::COL_BLACK)
  ) else $error("pixels valid while generator disabled");

  enabled_runs_a: assert property (
    gen_en |=> pixel_valid
  ) else $error("generator enabled but no pixel");

  compliance_wins_a: assert property (
    (src == tps_pkg::SRC_COMPLIANCE) && !chk_inv |=>
      (pix_rgb == tps_pkg::CMP_EVEN) || (pix_rgb == tps_pkg::CMP_ODD)
  ) else $error("compliance pattern not shown");

  priority_order_a: assert property (
    gen_en && s_q.ctrl[tps_pkg::CTRL_CMP_BIT] |->
      (src == tps_pkg::SRC_COMPLIANCE)
  ) else $error("compliance not given priority");

  bars_first_a: assert property (
    (src == tps_pkg::SRC_BARS) && chk_x0 && !chk_inv |=>
      (pix_rgb == tps_pkg::COL_WHITE)
  ) else $error("first colour bar not white");

  solid_white_a: assert property (
    chk_white && !chk_inv |=> (pix_rgb == tps_pkg::COL_WHITE)
  ) else $error("solid white pattern wrong");

  invert_black_a: assert property (
    chk_white && chk_inv |=> (pix_rgb == tps_pkg::COL_BLACK)
  ) else $error("inverted white is not black");

  ramp_start_a: assert property (
    chk_ramp && chk_x0 && !chk_inv |=> (pix_rgb == tps_pkg::COL_BLACK)
  ) else $error("horizontal ramp does not start black");

  fixed_follow_a: assert property (
    !auto_on |=> (s_q.cur == $past(s_q.ctrl[7:4]))
  ) else $error("code does not follow choice field");

  auto_hold_a: assert property (
    auto_on && !frame_end |=> $stable(s_q.cur)
  ) else $error("code changed inside auto step");

  auto_step_a: assert property (
    auto_on && frame_end && step_due && (s_q.cur < tps_pkg::CODE_LAST) |=>
      (s_q.cur == $past(s_q.cur) + 4'h1) && (s_q.frames == 8'h00)
  ) else $error("auto advance did not step");

  write_answer_a: assert property (
    s_q.aw_have && s_q.w_have && !s_q.bvalid |=> s_axi_bvalid
  ) else $error("write response missing");

  cover_compliance_c: cover property (src == tps_pkg::SRC_COMPLIANCE);
  cover_bars_c: cover property (src == tps_pkg::SRC_BARS);
  cover_auto_step_c: cover property (auto_on && frame_end && step_due);
  cover_custom_c: cover property ((src == tps_pkg::SRC_CHOICE) &&
                                  (s_q.cur == tps_pkg::CODE_LAST));

endmodule : tps_pattern_ctrl

// ---- test/test_test_pattern_select_control.sv ----
// bench for the pattern control block: registers, pixels, auto advance
`timescale 1ns/10ps
module test_test_pattern_select_control;
  localparam int H = 8; // short line keeps frames cheap
  localparam int V = 4; // short frame
  // colour tables as {red, green, blue}, first entry in the top bits
  localparam logic [191:0] BARS = 192'hFFFFFF_FFFF00_00FFFF_00FF00_FF00FF_FF0000_0000FF_000000;
  localparam logic [191:0] QUAD = 192'hFFFF00_00FFFF_0000FF_FF0000_0000FF_00FFFF_FFFF00_FF0000;
  localparam logic [119:0] SOLID = 120'hFFFFFF_000000_FF0000_00FF00_0000FF;
  localparam logic [95:0]  RAMP  = 96'hFFFFFF_FF0000_00FF00_0000FF;
  logic        aclk = 1'h0, aresetn = 1'h0;       // clock, reset
  logic        awvalid = 1'h0, wvalid = 1'h0;     // write requests
  logic        bready = 1'h0, arvalid = 1'h0;     // response, read
  logic        rready = 1'h0;                     // read data accept
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;      // byte addresses
  logic [31:0] wdata = 32'h0;                     // write word
  logic [23:0] cust = 24'h0;                      // custom colour model
  logic [7:0]  rnd = 8'h31;                       // lfsr state
  wire         awready, wready, bvalid, arready, rvalid, pv;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [7:0]   pr, pg, pb;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;

  tps_pattern_ctrl #(.H_ACTIVE(H), .V_ACTIVE(V)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pixel_valid(pv), .pixel_red(pr), .pixel_green(pg), .pixel_blue(pb));

  // free running clock and a cycle count for spacing reads
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end

  // prints counts and verdict, the only exit of the run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic fail(input string s);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, s);
  endtask : fail
  // register and response compare
  task automatic chk(input logic [31:0] g, input logic [31:0] e, string s);
    n_checks++;
    if (g !== e) fail(s);
  endtask : chk
  // pixel compare: valid flag plus colour
  task automatic chk_pix(input logic [24:0] g, input logic [24:0] e);
    n_checks++;
    if (g !== e) fail($sformatf("pixel %h want %h", g, e));
  endtask : chk_pix
  // bounded wait step; a stuck handshake ends the run
  task automatic tick(inout int n);
    n++;
    if (n > 200) begin
      fail("timeout");
      close_out;
    end
  endtask : tick
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // one write; readies are sampled at the falling edge so no race
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e = tps_pkg::RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] r;
    int n = 0;
    @(posedge aclk);
    awvalid <= 1'h1; awaddr <= a; wvalid <= 1'h1;
    wdata <= {24'h0, d}; bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready; tw = wvalid & wready;
      tb = bvalid === 1'h1; r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      tick(n);
    end while (!tb);
    bready <= 1'h0;
    chk({30'h0, r}, {30'h0, e}, "write response");
  endtask : wr
  // one read, data and response returned
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    int n = 0;
    @(posedge aclk);
    arvalid <= 1'h1; araddr <= a; rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready; tr = rvalid === 1'h1; d = rdata; r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      tick(n);
    end while (!tr);
    rready <= 1'h0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = tps_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask : rc

  // expected pixel; priority compliance, bars, quad, choice field
  function automatic logic [23:0] pix(logic [7:0] c, g, int x, y);
    logic [23:0] p;
    logic [7:0]  l;
    int          k;
    k = c[7:4];
    l = (k < 10) ? 8'(x * 256 / H) : 8'(y * 256 / V);
    if (c[3]) p = ((x ^ y) & 1) ? tps_pkg::CMP_ODD : tps_pkg::CMP_EVEN;
    else if (c[2]) p = BARS[(7 - x * 8 / H) * 24 +: 24];
    else if (g[2]) p = QUAD[(7 - (c[1] ? 4 : 0) - x * 4 / H) * 24 +: 24];
    else if (k >= 1 && k <= 5) p = SOLID[(5 - k) * 24 +: 24];
    else if (k >= 6 && k <= 13) p = RAMP[(3 - (k - 6) % 4) * 24 +: 24] & {3{l}};
    else if (k == 14) p = cust;
    else p = 24'h0; // reserved codes show black
    return g[1] ? ~p : p;
  endfunction : pix

  // restart the scan from a disabled state and compare one whole frame
  task automatic frame(input logic [7:0] c, input logic [7:0] g);
    int n = 0;
    // park the scan with the new code; the code follows a cycle late
    wr(tps_pkg::ADDR_CTRL, c & 8'hFE);
    wr(tps_pkg::ADDR_CFG, g);
    wr(tps_pkg::ADDR_CTRL, c | 8'h01);
    do begin
      @(negedge aclk);
      tick(n);
    end while (pv !== 1'h1);
    for (int y = 0; y < V; y++)
      for (int x = 0; x < H; x++) begin
        if (x + y > 0) @(negedge aclk);
        chk_pix({pv, pr, pg, pb}, {1'h1, pix(c, g, x, y)});
      end
  endtask : frame

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] sp [6] = '{16'h0400, 16'h0C04, 16'h0004, 16'h0204,
                            16'h0402, 16'h0206};
    int          t, s;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rc(tps_pkg::ADDR_CTRL, 32'h10);
    rc(tps_pkg::ADDR_CFG, 32'h0);
    rc(8'h40, 32'h0, tps_pkg::RESP_SLVERR);
    wr(8'h40, 8'hFF, tps_pkg::RESP_SLVERR);
    $display("test reset and map done");
    // random custom colour through the three level registers
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      cust[(2 - i) * 8 +: 8] = rnd;
      wr(tps_pkg::ADDR_RED + 8'(4 * i), rnd);
    end
    rc(tps_pkg::ADDR_BLUE, {24'h0, cust[7:0]});
    for (int v = 0; v < 2; v++)
      for (int k = 0; k < 16; k++) frame(8'(k << 4), 8'(v << 1));
    $display("test choice codes done");
    for (int i = 0; i < 6; i++) frame(sp[i][15:8], sp[i][7:0]);
    $display("test overrides done");
    // disabled generator gives no valid pixels
    wr(tps_pkg::ADDR_CTRL, 8'h10);
    repeat (3) @(negedge aclk);
    chk_pix({pv, pr, pg, pb}, 25'h0);
    $display("test disable done");
    // auto advance every two frames; choice field writes ignored
    wr(tps_pkg::ADDR_FTIME, 8'h02);
    wr(tps_pkg::ADDR_CFG, 8'h01);
    wr(tps_pkg::ADDR_CTRL, 8'h31);
    @(negedge aclk);
    t = cyc;
    rd(tps_pkg::ADDR_STAT, d, r);
    s = d[3:0];
    wr(tps_pkg::ADDR_CTRL, 8'h91);
    while (cyc < t + 2 * H * V) @(negedge aclk);
    rd(tps_pkg::ADDR_STAT, d, r);
    chk({28'h0, d[3:0]}, (s == 14) ? 1 : s + 1, "auto step");
    chk({31'h0, d[4]}, 32'h1, "status running");
    $display("test auto advance done");
    close_out;
  end
endmodule : test_test_pattern_select_control
